// file: src/i2cm_defines.svh
`ifndef I2CM_DEFINES_SVH
`define I2CM_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define I2CM_OFF_ADDR_DIR   16'hff80
`define I2CM_OFF_TX_FIRST   16'hff81
`define I2CM_OFF_TX_SECOND  16'hff82
`define I2CM_OFF_RX_FIRST   16'hff83
`define I2CM_OFF_RX_SECOND  16'hff84
`define I2CM_OFF_CTRL_STAT  16'hff85

// ****************************************
// Field positions, reset value and read fill value
// ****************************************
`define I2CM_DIR_BIT        0
`define I2CM_ADDR_MSB       7
`define I2CM_ADDR_LSB       1
`define I2CM_LEN_BIT        0
`define I2CM_GO_BIT         1
`define I2CM_ACKERR_BIT     2
`define I2CM_REG_RESET      8'h00
`define I2CM_READ_FILL      8'hff

// ****************************************
// Timing
// ****************************************
`define I2CM_BUS_RATE_KHZ   400
`define I2CM_TB_CNT_W       8

`endif

// file: src/i2cm_pkg.sv
package i2cm_pkg;

  typedef enum logic [2:0] {
    I2CM_IDLE,
    I2CM_START,
    I2CM_DATA,
    I2CM_ACK,
    I2CM_STOP
  } i2cm_state_t;

  typedef enum logic [1:0] {
    I2CM_BYTE_ADDR,
    I2CM_BYTE_FIRST,
    I2CM_BYTE_SECOND
  } i2cm_byte_t;

endpackage

// file: src/i2cm_tbase.sv
`timescale 1ns/1ps
`include "i2cm_defines.svh"

module i2cm_tbase
  import i2cm_pkg::*;
#(
  parameter int CNT_W = `I2CM_TB_CNT_W
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // Time-base clock, asynchronous
  input  wire logic tb_clk,
  // Phase events
  output logic      tb_rise,
  output logic      tb_fall,
  output logic      tb_mid,
  output logic      tb_high
);

  logic             sync1_r;
  logic             sync2_r;
  logic             last_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] half_r;
  logic [CNT_W-1:0] half_nxt;
  logic             edge_s;

  assign edge_s  = sync2_r ^ last_r;
  assign tb_rise = edge_s & sync2_r;
  assign tb_fall = edge_s & ~sync2_r;
  assign tb_high = sync2_r;
  // Mid point of each half period, from the last measured half
  assign tb_mid  = ~edge_s && (half_r != '0) && (cnt_r == (half_r >> 1));

  always_comb begin
    cnt_nxt  = cnt_r;
    half_nxt = half_r;
    if (edge_s) begin
      half_nxt = cnt_r;
      cnt_nxt  = CNT_W'(1);
    end else if (cnt_r != '1) begin
      // Saturates so a stalled time base never fakes a second mid point
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r  <= 1'b0;
      cnt_r   <= '0;
      half_r  <= '0;
    end else begin
      sync1_r <= tb_clk;
      sync2_r <= sync1_r;
      last_r  <= sync2_r;
      cnt_r   <= cnt_nxt;
      half_r  <= half_nxt;
    end
  end

endmodule

// file: src/i2cm_top.sv
`timescale 1ns/1ps
`include "i2cm_defines.svh"

// Overview of operation
// - Address comes from bits 7..1; bit 0 chooses write (0) or read (1).
// - First transmit register is sent as first data byte of a write.
// - With length bit set, second transmit register is sent second.
// - First byte received in a read lands in the first receive register.
// - With length bit set, second received byte lands in second register.
// - Ack-error bit sets whenever a sampled slave acknowledge is not zero.
// - Ack-error bit clears automatically when a new transaction begins.
// - Start bit stays high while busy, self-clears at end of transaction.
// - Length bit one means two-byte transfers, zero means single byte.
// - Completion flag rises at end of frame, drops at next start.
// - Bus clock follows the 400 kHz time-base clock.

module i2cm_top
  import i2cm_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Special-function register port
  input  wire logic [15:0] sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  // Time-base clock
  input  wire logic        tb_clk,
  // Completion towards external interrupt six
  output logic             xfer_done_flag,
  // Two-wire bus, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic sfr_hit(input logic [15:0] a, input logic [15:0] off);
    sfr_hit = (a == off);
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [7:0]  slave_addr_dir_r;
  logic [7:0]  slave_addr_dir_nxt;
  logic [7:0]  first_tx_byte_r;
  logic [7:0]  first_tx_byte_nxt;
  logic [7:0]  second_tx_byte_r;
  logic [7:0]  second_tx_byte_nxt;
  logic [7:0]  first_rx_byte_r;
  logic [7:0]  first_rx_byte_nxt;
  logic [7:0]  second_rx_byte_r;
  logic [7:0]  second_rx_byte_nxt;
  logic        two_byte_select_r;
  logic        two_byte_select_nxt;
  logic        go_busy_r;
  logic        go_busy_nxt;
  logic        ack_error_r;
  logic        ack_error_nxt;
  logic        done_r;
  logic        done_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  i2cm_state_t state_r;
  i2cm_state_t state_nxt;
  i2cm_byte_t  byte_r;
  i2cm_byte_t  byte_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic [2:0]  bit_r;
  logic [2:0]  bit_nxt;
  logic        nack_r;
  logic        nack_nxt;
  logic        scl_oe_r;
  logic        scl_oe_nxt;
  logic        sda_oe_r;
  logic        sda_oe_nxt;
  logic        scl_s1_r;
  logic        scl_s2_r;
  logic        sda_s1_r;
  logic        sda_s2_r;
  logic        tb_rise;
  logic        tb_fall;
  logic        tb_mid;
  logic        tb_high;
  logic        mid_lo;
  logic        mid_hi;
  logic        read_dir;
  logic        rxing;
  logic        last_byte;
  logic        launch;

  // ****************************************
  // Time base
  // ****************************************
  i2cm_tbase #(.CNT_W(`I2CM_TB_CNT_W)) u_tbase (
    .mclk    (mclk),
    .reset_n (reset_n),
    .tb_clk  (tb_clk),
    .tb_rise (tb_rise),
    .tb_fall (tb_fall),
    .tb_mid  (tb_mid),
    .tb_high (tb_high)
  );

  assign mid_lo    = tb_mid & ~tb_high;
  assign mid_hi    = tb_mid & tb_high;
  assign read_dir  = slave_addr_dir_r[`I2CM_DIR_BIT];
  assign rxing     = read_dir && (byte_r != I2CM_BYTE_ADDR);
  assign last_byte = (byte_r == I2CM_BYTE_SECOND) ||
                     ((byte_r == I2CM_BYTE_FIRST) && !two_byte_select_r);
  assign launch    = sfr_wr && sfr_hit(sfr_addr, `I2CM_OFF_CTRL_STAT) &&
                     sfr_wdata[`I2CM_GO_BIT] && !go_busy_r;

  // ****************************************
  // Register file and frame engine
  // ****************************************
  always_comb begin
    slave_addr_dir_nxt  = slave_addr_dir_r;
    first_tx_byte_nxt   = first_tx_byte_r;
    second_tx_byte_nxt  = second_tx_byte_r;
    first_rx_byte_nxt   = first_rx_byte_r;
    second_rx_byte_nxt  = second_rx_byte_r;
    two_byte_select_nxt = two_byte_select_r;
    go_busy_nxt         = go_busy_r;
    ack_error_nxt       = ack_error_r;
    done_nxt            = done_r;
    rdata_nxt           = rdata_r;
    state_nxt           = state_r;
    byte_nxt            = byte_r;
    shift_nxt           = shift_r;
    bit_nxt             = bit_r;
    nack_nxt            = nack_r;
    scl_oe_nxt          = scl_oe_r;
    sda_oe_nxt          = sda_oe_r;

    // Plain storage; software keeps off these while busy
    if (sfr_wr) begin
      if (sfr_hit(sfr_addr, `I2CM_OFF_ADDR_DIR)) begin
        slave_addr_dir_nxt = sfr_wdata;
      end else if (sfr_hit(sfr_addr, `I2CM_OFF_TX_FIRST)) begin
        first_tx_byte_nxt = sfr_wdata;
      end else if (sfr_hit(sfr_addr, `I2CM_OFF_TX_SECOND)) begin
        second_tx_byte_nxt = sfr_wdata;
      end else if (sfr_hit(sfr_addr, `I2CM_OFF_CTRL_STAT)) begin
        // Length frozen mid-frame so the byte count cannot shift under us
        if (!go_busy_r) begin
          two_byte_select_nxt = sfr_wdata[`I2CM_LEN_BIT];
        end
      end
    end

    if (sfr_rd) begin
      if (sfr_hit(sfr_addr, `I2CM_OFF_ADDR_DIR)) begin
        rdata_nxt = slave_addr_dir_r;
      end else if (sfr_hit(sfr_addr, `I2CM_OFF_TX_FIRST)) begin
        rdata_nxt = first_tx_byte_r;
      end else if (sfr_hit(sfr_addr, `I2CM_OFF_TX_SECOND)) begin
        rdata_nxt = second_tx_byte_r;
      end else if (sfr_hit(sfr_addr, `I2CM_OFF_RX_FIRST)) begin
        rdata_nxt = first_rx_byte_r;
      end else if (sfr_hit(sfr_addr, `I2CM_OFF_RX_SECOND)) begin
        rdata_nxt = second_rx_byte_r;
      end else if (sfr_hit(sfr_addr, `I2CM_OFF_CTRL_STAT)) begin
        rdata_nxt = `I2CM_REG_RESET;
        rdata_nxt[`I2CM_ACKERR_BIT] = ack_error_r;
        rdata_nxt[`I2CM_GO_BIT]     = go_busy_r;
        rdata_nxt[`I2CM_LEN_BIT]    = two_byte_select_r;
      end else begin
        rdata_nxt = `I2CM_REG_RESET;
      end
    end

    // SCL follows the time base once a frame owns the bus
    if (state_r != I2CM_IDLE) begin
      if (tb_rise) begin
        scl_oe_nxt = 1'b0;
      end else if (tb_fall && state_r != I2CM_STOP) begin
        scl_oe_nxt = 1'b1;
      end
    end

    case (state_r)
      I2CM_IDLE: begin
        scl_oe_nxt = 1'b0;
        sda_oe_nxt = 1'b0;
        if (launch) begin
          go_busy_nxt   = 1'b1;
          ack_error_nxt = 1'b0;
          done_nxt      = 1'b0;
          nack_nxt      = 1'b0;
          state_nxt     = I2CM_START;
        end
      end
      I2CM_START: begin
        // Start only over an idle bus: both lines seen high
        if (mid_hi && !sda_oe_r && scl_s2_r && sda_s2_r) begin
          sda_oe_nxt = 1'b1;
        end else if (tb_fall && sda_oe_r) begin
          shift_nxt = slave_addr_dir_r;
          bit_nxt   = 3'h0;
          byte_nxt  = I2CM_BYTE_ADDR;
          state_nxt = I2CM_DATA;
        end else if (tb_fall) begin
          scl_oe_nxt = 1'b0;
        end
      end
      I2CM_DATA: begin
        if (mid_lo) begin
          sda_oe_nxt = rxing ? 1'b0 : ~shift_r[7];
        end else if (mid_hi && rxing) begin
          shift_nxt = {shift_r[6:0], sda_s2_r};
        end else if (tb_fall) begin
          shift_nxt = rxing ? shift_r : {shift_r[6:0], 1'b0};
          bit_nxt = bit_r + 3'h1;
          if (bit_r == 3'h7) begin
            state_nxt = I2CM_ACK;
          end
        end
      end
      I2CM_ACK: begin
        if (mid_lo) begin
          // Master acks all but the last byte it reads
          sda_oe_nxt = rxing && !last_byte;
        end else if (mid_hi && !rxing && sda_s2_r) begin
          ack_error_nxt = 1'b1;
          nack_nxt      = 1'b1;
        end else if (tb_fall) begin
          if (rxing && byte_r == I2CM_BYTE_FIRST) begin
            first_rx_byte_nxt = shift_r;
          end else if (rxing && byte_r == I2CM_BYTE_SECOND) begin
            second_rx_byte_nxt = shift_r;
          end
          if (nack_r || (byte_r != I2CM_BYTE_ADDR && last_byte)) begin
            state_nxt = I2CM_STOP;
          end else if (byte_r == I2CM_BYTE_ADDR) begin
            byte_nxt  = I2CM_BYTE_FIRST;
            shift_nxt = read_dir ? `I2CM_READ_FILL : first_tx_byte_r;
            state_nxt = I2CM_DATA;
          end else begin
            byte_nxt  = I2CM_BYTE_SECOND;
            shift_nxt = second_tx_byte_r;
            state_nxt = I2CM_DATA;
          end
        end
      end
      I2CM_STOP: begin
        if (mid_lo && scl_oe_r) begin
          sda_oe_nxt = 1'b1;
        end else if (mid_hi && !scl_oe_r) begin
          sda_oe_nxt  = 1'b0;
          go_busy_nxt = 1'b0;
          done_nxt    = 1'b1;
          state_nxt   = I2CM_IDLE;
        end
      end
      default: begin
        state_nxt = I2CM_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slave_addr_dir_r  <= `I2CM_REG_RESET;
      first_tx_byte_r   <= `I2CM_REG_RESET;
      second_tx_byte_r  <= `I2CM_REG_RESET;
      first_rx_byte_r   <= `I2CM_REG_RESET;
      second_rx_byte_r  <= `I2CM_REG_RESET;
      two_byte_select_r <= 1'b0;
      go_busy_r         <= 1'b0;
      ack_error_r       <= 1'b0;
      done_r            <= 1'b0;
      rdata_r           <= `I2CM_REG_RESET;
      state_r           <= I2CM_IDLE;
      byte_r            <= I2CM_BYTE_ADDR;
      shift_r           <= `I2CM_REG_RESET;
      bit_r             <= 3'h0;
      nack_r            <= 1'b0;
      scl_oe_r          <= 1'b0;
      sda_oe_r          <= 1'b0;
      scl_s1_r          <= 1'b1;
      scl_s2_r          <= 1'b1;
      sda_s1_r          <= 1'b1;
      sda_s2_r          <= 1'b1;
    end else begin
      slave_addr_dir_r  <= slave_addr_dir_nxt;
      first_tx_byte_r   <= first_tx_byte_nxt;
      second_tx_byte_r  <= second_tx_byte_nxt;
      first_rx_byte_r   <= first_rx_byte_nxt;
      second_rx_byte_r  <= second_rx_byte_nxt;
      two_byte_select_r <= two_byte_select_nxt;
      go_busy_r         <= go_busy_nxt;
      ack_error_r       <= ack_error_nxt;
      done_r            <= done_nxt;
      rdata_r           <= rdata_nxt;
      state_r           <= state_nxt;
      byte_r            <= byte_nxt;
      shift_r           <= shift_nxt;
      bit_r             <= bit_nxt;
      nack_r            <= nack_nxt;
      scl_oe_r          <= scl_oe_nxt;
      sda_oe_r          <= sda_oe_nxt;
      scl_s1_r          <= scl_i;
      scl_s2_r          <= scl_s1_r;
      sda_s1_r          <= sda_i;
      sda_s2_r          <= sda_s1_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Open drain: only ever pulls low
  assign scl_o          = 1'b0;
  assign sda_o          = 1'b0;
  assign scl_oe         = scl_oe_r;
  assign sda_oe         = sda_oe_r;
  assign sfr_rdata      = rdata_r;
  assign xfer_done_flag = done_r;

endmodule

// file: tb/i2cm_chk.sv
`timescale 1ns/1ps
`include "i2cm_defines.svh"

module i2cm_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // Register port
  input wire logic [15:0] sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  // Completion and bus
  input wire logic        xfer_done_flag,
  input wire logic        scl_oe,
  input wire logic        sda_oe
);
  logic       busy_r, busy_nxt, busy_w, launch, scl_q_r;
  logic [5:0] hold_r, hold_nxt;

  // Busy as software would read it
  assign busy_w = busy_r & ~xfer_done_flag;
  assign launch = sfr_wr && sfr_addr == `I2CM_OFF_CTRL_STAT
                  && sfr_wdata[`I2CM_GO_BIT] && !busy_w;

  always_comb begin
    busy_nxt = launch | busy_w;
    hold_nxt = (busy_w && scl_oe == scl_q_r) ? hold_r + 6'h01 : 6'h00;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r  <= 1'b0;
      scl_q_r <= 1'b0;
      hold_r  <= 6'h00;
    end else begin
      busy_r  <= busy_nxt;
      scl_q_r <= scl_oe;
      hold_r  <= hold_nxt;
    end
  end

  default clocking dcb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_launch_drops_done: assert property (
    launch |=> !xfer_done_flag) else $error("done kept at launch");
  a_done_holds_level: assert property (
    xfer_done_flag && !launch |=> xfer_done_flag) else $error("done dropped early");
  a_idle_bus_free: assert property (
    !busy_r |-> !scl_oe && !sda_oe) else $error("bus pulled while idle");
  a_done_ends_frame: assert property (
    $rose(xfer_done_flag) |-> busy_r && !scl_oe && !sda_oe) else $error("done off frame end");
  a_status_readback: assert property (
    sfr_rd && sfr_addr == `I2CM_OFF_CTRL_STAT |=> sfr_rdata[7:3] == 5'h00
      && sfr_rdata[1] == $past(busy_w)) else $error("status read wrong");
  a_unmapped_zero: assert property (sfr_rd && sfr_addr > `I2CM_OFF_CTRL_STAT
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_start_in_frame: assert property (
    $rose(sda_oe) && !scl_oe |-> busy_r) else $error("start outside frame");
  a_scl_keeps_running: assert property (
    hold_r < 6'd40) else $error("bus clock stalled");

  c_two_byte: cover property (launch && sfr_wdata[`I2CM_LEN_BIT]);
  c_frame_done: cover property ($rose(xfer_done_flag));
  c_start_seen: cover property ($rose(sda_oe) && !scl_oe);
endmodule

bind i2cm_top i2cm_chk u_chk (
  .mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xfer_done_flag(xfer_done_flag),
  .scl_oe(scl_oe), .sda_oe(sda_oe)
);

// file: tb/i2cm_slave.sv
`timescale 1ns/1ps

module i2cm_slave (
  // Wire levels
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_oe,
  // Behaviour and observed writes
  input  wire logic [6:0] my_addr,
  input  wire logic       nack_data,
  input  wire logic [7:0] rd1,
  input  wire logic [7:0] rd2,
  output logic [7:0]      wr1,
  output logic [7:0]      wr2,
  output logic [1:0]      wcnt
);
  // Changes only after SCL falls, so never mimics start or stop
  task automatic put_bit(logic v);
    @(negedge scl);
    #1 sda_oe = ~v;
  endtask

  task automatic get_byte(output logic [7:0] b);
    put_bit(1'b1);
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
  endtask

  task automatic frame();
    logic [7:0] b;
    logic       m;
    get_byte(b);
    if (b[7:1] != my_addr) return;
    put_bit(1'b0);
    if (b[0]) begin
      for (int k = 0; k < 2; k++) begin
        for (int i = 7; i >= 0; i--) put_bit(k == 0 ? rd1[i] : rd2[i]);
        put_bit(1'b1);
        @(posedge scl);
        m = sda;
        if (m) return;
      end
    end else forever begin
      get_byte(b);
      if (wcnt == 2'd0) wr1 = b;
      else wr2 = b;
      wcnt = wcnt + 2'd1;
      put_bit(nack_data);
    end
  endtask

  initial begin
    sda_oe = 1'b0;
    wcnt   = 2'd0;
    forever begin
      @(negedge sda iff scl);
      wcnt = 2'd0;
      fork
        frame();
        @(posedge sda iff scl);
      join_any
      disable fork;
      sda_oe = 1'b0;
    end
  end
endmodule

// file: tb/i2cm_top_bench.sv
`timescale 1ns/1ps
`include "i2cm_defines.svh"

module i2cm_top_bench;
  logic        mclk, reset_n, tb_clk, sfr_wr, sfr_rd, done, scl_oe, sda_oe, s_oe, nack_data;
  logic        scl_o, sda_o;
  logic [15:0] sfr_addr;
  logic [7:0]  sfr_wdata, sfr_rdata, rd1, rd2, wr1, wr2;
  logic [6:0]  my_addr;
  logic [1:0]  wcnt;
  int          errors, checks;
  // Pad drives its output value while enabled, pull-up otherwise
  wire         scl = ~scl_oe | scl_o;
  wire         sda = (~sda_oe | sda_o) & ~s_oe;

  i2cm_top dut (
    .mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .tb_clk(tb_clk),
    .xfer_done_flag(done), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe)
  );
  i2cm_slave peer (
    .scl(scl), .sda(sda), .sda_oe(s_oe), .my_addr(my_addr), .nack_data(nack_data),
    .rd1(rd1), .rd2(rd2), .wr1(wr1), .wr2(wr2), .wcnt(wcnt)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    tb_clk = 1'b0;
    #5;
    forever #32 tb_clk = ~tb_clk;
  end

  task automatic ck(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge mclk);
    #1;
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(posedge mclk);
    #1;
    sfr_wr = 1'b0;
  endtask

  task automatic rk(string what, logic [15:0] a, logic [7:0] exp);
    @(posedge mclk);
    #1;
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(posedge mclk);
    #1;
    sfr_rd = 1'b0;
    ck(what, exp, sfr_rdata);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Launch a frame, wait boundedly for completion, then read status
  task automatic run(logic [7:0] ad, logic [7:0] xfer_control_status, logic [7:0] fin);
    int n;
    n = 0;
    wr(`I2CM_OFF_ADDR_DIR, ad);
    wr(`I2CM_OFF_CTRL_STAT, xfer_control_status);
    ck("done at launch", 8'h00, {7'h00, done});
    rk("busy", `I2CM_OFF_CTRL_STAT, {6'h00, 1'b1, xfer_control_status[0]});
    while (done !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    ck("done", 8'h01, {7'h00, done});
    if (done !== 1'b1) wrap_up();
    rk("status", `I2CM_OFF_CTRL_STAT, fin);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 7; i++) rk("reset", `I2CM_OFF_ADDR_DIR + 16'(i), 8'h00);
    wr(`I2CM_OFF_ADDR_DIR, 8'ha5);
    wr(`I2CM_OFF_TX_FIRST, 8'h3c);
    wr(`I2CM_OFF_TX_SECOND, 8'hc3);
    wr(`I2CM_OFF_RX_FIRST, 8'h77);
    wr(16'hff86, 8'h5a);
    rk("addr_dir", `I2CM_OFF_ADDR_DIR, 8'ha5);
    rk("tx first", `I2CM_OFF_TX_FIRST, 8'h3c);
    rk("tx second", `I2CM_OFF_TX_SECOND, 8'hc3);
    rk("rx first ro", `I2CM_OFF_RX_FIRST, 8'h00);
    rk("unmapped", 16'hff86, 8'h00);
    $display("test regs finished");
  endtask

  task automatic t_write_two();
    run(8'ha0, 8'h03, 8'h01);
    ck("count", 8'h02, {6'h00, wcnt});
    ck("byte one", 8'h3c, wr1);
    ck("byte two", 8'hc3, wr2);
    $display("test write two finished");
  endtask

  task automatic t_read_two();
    rd1 = 8'h5a;
    rd2 = 8'h96;
    run(8'ha1, 8'h03, 8'h01);
    rk("rx first", `I2CM_OFF_RX_FIRST, 8'h5a);
    rk("rx second", `I2CM_OFF_RX_SECOND, 8'h96);
    $display("test read two finished");
  endtask

  task automatic t_read_one();
    rd1 = 8'h81;
    rd2 = 8'h18;
    run(8'ha1, 8'h02, 8'h00);
    rk("rx first", `I2CM_OFF_RX_FIRST, 8'h81);
    rk("rx second kept", `I2CM_OFF_RX_SECOND, 8'h96);
    $display("test read one finished");
  endtask

  task automatic t_no_device();
    run(8'h44, 8'h02, 8'h04);
    ck("count", 8'h00, {6'h00, wcnt});
    $display("test no device finished");
  endtask

  task automatic t_write_one();
    wr(`I2CM_OFF_TX_FIRST, 8'he7);
    run(8'ha0, 8'h02, 8'h00);
    ck("count", 8'h01, {6'h00, wcnt});
    ck("byte one", 8'he7, wr1);
    $display("test write one finished");
  endtask

  task automatic t_data_nack();
    nack_data = 1'b1;
    run(8'ha0, 8'h03, 8'h05);
    nack_data = 1'b0;
    ck("count", 8'h01, {6'h00, wcnt});
    $display("test data nack finished");
  endtask

  initial begin
    errors    = 0;
    checks    = 0;
    reset_n   = 1'b0;
    sfr_addr  = 16'h0000;
    sfr_wdata = 8'h00;
    {sfr_wr, sfr_rd, nack_data} = 3'b000;
    my_addr   = 7'h50;
    {rd1, rd2} = 16'h0000;
    repeat (16) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    t_regs();
    t_write_two();
    t_read_two();
    t_read_one();
    t_no_device();
    t_write_one();
    t_data_nack();
    wrap_up();
  end
endmodule
